// ==== hdl/srlm_pkg.sv ====
// Constants, types and helper functions of the signalling link receive monitor.
package srlm_pkg;

  // ****************************************************************
  // Line coding
  // ****************************************************************
  localparam logic [2:0]  ONES_STUFF      = 3'h5;
  localparam logic [2:0]  ONES_FLAG       = 3'h6;
  localparam logic [2:0]  ONES_ABORT      = 3'h7;
  localparam logic [2:0]  LAST_BIT        = 3'h7;

  // ****************************************************************
  // Check sequence
  // ****************************************************************
  localparam logic [15:0] CRC_INIT        = 16'hffff;
  localparam logic [15:0] CRC_POLY        = 16'h8408;
  localparam logic [15:0] CRC_GOOD        = 16'hf0b8;

  // ****************************************************************
  // Message lengths and reference store
  // ****************************************************************
  localparam logic [7:0]  FCS_OCTETS      = 8'h02;
  localparam logic [7:0]  REF_MIN_OCTETS  = 8'h03 + FCS_OCTETS;
  localparam logic [7:0]  REF_MAX_OCTETS  = 8'h05 + FCS_OCTETS;
  localparam logic [7:0]  MIN_FRAME_DEF   = 8'h05;
  localparam int          CAP_DEPTH       = 8;

  // ****************************************************************
  // Monitor counters and reset values
  // ****************************************************************
  localparam logic [5:0]  RATE_MAX        = 6'h3f;
  localparam logic [5:0]  RATE_RESET      = 6'h00;
  localparam logic [3:0]  BAD_WRAP        = 4'hf;
  localparam logic [7:0]  GOOD_WRAP       = 8'hff;
  localparam logic [7:0]  GOOD_RESET      = 8'h00;
  localparam logic [7:0]  MAX_LEN_RESET   = 8'h00;

  typedef enum logic [1:0] {RX_HUNT, RX_FRAME, RX_DISCARD} srlm_rx_state_type;

  // Reflected CRC-16 over one octet, low bit first.
  function automatic logic [15:0] srlm_crc_octet(input logic [15:0] crc, input logic [7:0] octet);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ octet[i]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

endpackage

// ==== hdl/srlm_sync.sv ====
// Three-stage pin synchroniser that accepts a change once two stages agree.
`timescale 1ns/1ns
module srlm_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Asynchronous inputs and their clean copies
  input  wire logic [WIDTH-1:0] async_i,
  output      logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // The first stage feeds the second only, so a metastable value never fans out.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          sync_o[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule

// ==== hdl/srlm_top.sv ====
// Receive signalling link monitor: deframer, repeat-message filter and error-rate monitor.
`timescale 1ns/1ns
module srlm_top
  import srlm_pkg::*;
#(
  parameter logic [7:0] MIN_FRAME_OCTETS = MIN_FRAME_DEF
) (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RESET_N_I,
  // Serial receive link pins
  input  wire logic       RX_LINK_CLK_I,
  input  wire logic       RX_LINK_DATA_I,
  // Channel configuration
  input  wire logic       SIGNALLING_CRC16_CHANNEL_MODE_I,
  input  wire logic [7:0] MAX_FRAME_LEN_I,
  // Interrupt masks, high blocks the interrupt
  input  wire logic       MASK_FILTER_MATCH_I,
  input  wire logic       MASK_SHORT_FRAME_I,
  input  wire logic       MASK_LONG_FRAME_I,
  input  wire logic       MASK_CRC_ERROR_I,
  input  wire logic       MASK_COUNT_UP_I,
  input  wire logic       MASK_COUNT_DOWN_I,
  // Receive buffer octet stream
  output      logic [7:0] RX_OCTET_O,
  output      logic       RX_OCTET_VALID_O,
  // Message status
  output      logic       RX_MSG_END_O,
  output      logic       RX_MSG_GOOD_O,
  output      logic       RX_MSG_FILTERED_O,
  // Monitor state
  output      logic       FILTERING_O,
  output      logic       OCTET_COUNTING_O,
  output      logic [5:0] UNIT_ERROR_RATE_COUNTER_O,
  // Interrupt pulses
  output      logic       FILTER_MATCH_INTERRUPT_O,
  output      logic       SHORT_FRAME_ERROR_O,
  output      logic       LONG_FRAME_ERROR_O,
  output      logic       CRC_ERROR_INTERRUPT_O,
  output      logic       ERROR_COUNT_UP_INTERRUPT_O,
  output      logic       ERROR_COUNT_DOWN_INTERRUPT_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [1:0]        pins_s;
  logic              lclk_s;
  logic              din;
  logic              lclk_prev_reg;
  logic              bit_en;
  logic [2:0]        ones_reg;
  logic              is_flag;
  logic              is_abort;
  logic              is_stuff;
  srlm_rx_state_type st_reg;
  logic              data_bit;
  logic [7:0]        sh_reg;
  logic [2:0]        bit_cnt_reg;
  logic [7:0]        oct_cnt_reg;
  logic [15:0]       crc_reg;
  logic              octet_done;
  logic [7:0]        octet_val;
  logic              frame_end;
  logic              msg_valid;
  logic              too_long;
  logic              short_err;
  logic              align_err;
  logic              crc_err;
  logic              msg_good;
  logic              qualify;
  logic [7:0]        cap_mem [CAP_DEPTH];
  logic [7:0]        ref_mem [CAP_DEPTH];
  logic [7:0]        ref_len_reg;
  logic              filt_reg;
  logic              ref_bit;
  logic              cmp_fail;
  logic              lead_prefix;
  logic              pre_miss_reg;
  logic              filter_match;
  logic              filt_exit;
  logic              ref_load;
  logic [3:0]        rep_cnt_reg;
  logic [3:0]        rep_end_reg;
  logic              rep_busy;
  logic              end_pend_reg;
  logic              ocm_reg;
  logic              ocm_enter;
  logic [2:0]        line_bits_reg;
  logic              line_tick;
  logic [3:0]        bad_reg;
  logic              bad_wrap;
  logic [7:0]        good_reg;
  logic              good_wrap;
  logic              err_evt;
  logic [1:0]        up_n;
  logic [7:0]        rate_sum;
  logic [5:0]        rate_next;
  logic [5:0]        rate_reg;

  // ****************************************************************
  // Link pin sampling
  // ****************************************************************
  srlm_sync #(.WIDTH(2)) u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   ({RX_LINK_CLK_I, RX_LINK_DATA_I}),
    .sync_o    (pins_s)
  );

  assign lclk_s = pins_s[1];
  assign din    = pins_s[0];

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lclk_prev_reg <= 1'b0;
    end else begin
      lclk_prev_reg <= lclk_s;
    end
  end

  // Both pins share the same delay, so data sampled at the clock's rise is settled.
  assign bit_en = SIGNALLING_CRC16_CHANNEL_MODE_I && lclk_s && !lclk_prev_reg;

  // ****************************************************************
  // Flag, abort and stuffing detection
  // ****************************************************************
  always_comb begin
    is_flag  = 1'b0;
    is_abort = 1'b0;
    is_stuff = 1'b0;
    if (bit_en) begin
      if (din) begin
        is_abort = (ones_reg == ONES_ABORT - 3'h1);
      end else if (ones_reg == ONES_FLAG) begin
        is_flag = 1'b1;
      end else begin
        is_stuff = (ones_reg == ONES_STUFF);
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ones_reg <= 3'h0;
    end else if (bit_en) begin
      if (!din) begin
        ones_reg <= 3'h0;
      end else if (ones_reg != ONES_ABORT) begin
        ones_reg <= ones_reg + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Frame state
  // ****************************************************************
  assign data_bit   = bit_en && !is_flag && !is_abort && !is_stuff && (st_reg == RX_FRAME);
  assign octet_done = data_bit && (bit_cnt_reg == LAST_BIT);
  assign octet_val  = {din, sh_reg[7:1]};
  assign too_long   = octet_done && (oct_cnt_reg >= MAX_FRAME_LEN_I);
  assign frame_end  = is_flag && (st_reg == RX_FRAME);
  // The closing flag leaves seven of its bits in the counters, so a clean end shows bit count seven.
  assign msg_valid  = frame_end && !((oct_cnt_reg == 8'h00) && (bit_cnt_reg == LAST_BIT));
  assign short_err  = oct_cnt_reg < MIN_FRAME_OCTETS;
  assign align_err  = bit_cnt_reg != LAST_BIT;
  assign crc_err    = crc_reg != CRC_GOOD;
  assign msg_good   = msg_valid && !short_err && !align_err && !crc_err;
  assign qualify    = (oct_cnt_reg >= REF_MIN_OCTETS) && (oct_cnt_reg <= REF_MAX_OCTETS);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_reg <= RX_HUNT;
    end else begin
      case (st_reg)
        RX_HUNT: begin
          if (is_flag) begin
            st_reg <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          if (is_abort || too_long) begin
            st_reg <= RX_DISCARD;
          end
        end
        RX_DISCARD: begin
          if (is_flag) begin
            st_reg <= RX_FRAME;
          end
        end
        default: begin
          st_reg <= RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sh_reg      <= 8'h00;
      bit_cnt_reg <= 3'h0;
      oct_cnt_reg <= 8'h00;
      crc_reg     <= CRC_INIT;
    end else if (is_flag) begin
      bit_cnt_reg <= 3'h0;
      oct_cnt_reg <= 8'h00;
      crc_reg     <= CRC_INIT;
    end else if (data_bit) begin
      sh_reg      <= octet_val;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (octet_done) begin
        oct_cnt_reg <= oct_cnt_reg + 8'h01;
        crc_reg     <= srlm_crc_octet(crc_reg, octet_val);
      end
    end
  end

  // The first CAP_DEPTH (8) octets of the current message are captured so that they can be replayed or kept.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < CAP_DEPTH; i++) begin
        cap_mem[i] <= 8'h00;
      end
    end else if (octet_done && (oct_cnt_reg < 8'(CAP_DEPTH))) begin
      cap_mem[oct_cnt_reg[2:0]] <= octet_val;
    end
  end

  // ****************************************************************
  // Repeat-message filter
  // ****************************************************************
  assign ref_bit = ref_mem[oct_cnt_reg[2:0]][bit_cnt_reg];

  // An opening flag after an idle line shows its first seven bits as data, so a bit that
  // may still be such a flag only notes a mismatch, which the next real data bit declares.
  assign lead_prefix = (oct_cnt_reg == 8'h00) &&
                       (din ? ((bit_cnt_reg != 3'h0) && (bit_cnt_reg != LAST_BIT) &&
                               (ones_reg == bit_cnt_reg - 3'h1))
                            : (bit_cnt_reg == 3'h0));

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pre_miss_reg <= 1'b0;
    end else if (is_flag || octet_done || !filt_reg) begin
      pre_miss_reg <= 1'b0;
    end else if (data_bit && lead_prefix && (din != ref_bit)) begin
      pre_miss_reg <= 1'b1;
    end
  end

  // Past the reference length, a mismatch is declared only on a whole extra octet,
  // because the seven flag bits of a clean ending must not count as surplus data.
  assign cmp_fail = data_bit && filt_reg && !lead_prefix &&
                    ((oct_cnt_reg < ref_len_reg) ? ((din != ref_bit) || pre_miss_reg)
                                                 : (bit_cnt_reg == LAST_BIT));
  assign filter_match = msg_good && filt_reg && (oct_cnt_reg == ref_len_reg);
  assign filt_exit    = cmp_fail || (filt_reg && msg_valid && !filter_match) ||
                        (filt_reg && is_abort && (st_reg == RX_FRAME));
  assign ref_load     = msg_good && qualify && !filter_match;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      filt_reg <= 1'b0;
    end else if (!SIGNALLING_CRC16_CHANNEL_MODE_I) begin
      filt_reg <= 1'b0;
    end else if (ref_load) begin
      filt_reg <= 1'b1;
    end else if (filt_exit) begin
      filt_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ref_len_reg <= 8'h00;
      for (int i = 0; i < CAP_DEPTH; i++) begin
        ref_mem[i] <= 8'h00;
      end
    end else if (ref_load) begin
      ref_len_reg <= oct_cnt_reg;
      for (int i = 0; i < CAP_DEPTH; i++) begin
        ref_mem[i] <= cap_mem[i];
      end
    end
  end

  // Octets held back while filtering are replayed from the capture store once the
  // message turns out different; they match the reference, so nothing is lost.
  assign rep_busy = rep_cnt_reg != rep_end_reg;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rep_cnt_reg <= 4'h0;
      rep_end_reg <= 4'h0;
    end else if (cmp_fail) begin
      rep_cnt_reg <= 4'h0;
      rep_end_reg <= oct_cnt_reg[3:0] + {3'h0, octet_done};
    end else if (filt_reg && msg_valid && !filter_match) begin
      rep_cnt_reg <= 4'h0;
      rep_end_reg <= oct_cnt_reg[3:0];
    end else if (rep_busy) begin
      rep_cnt_reg <= rep_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RX_OCTET_O       <= 8'h00;
      RX_OCTET_VALID_O <= 1'b0;
    end else if (rep_busy) begin
      RX_OCTET_O       <= cap_mem[rep_cnt_reg[2:0]];
      RX_OCTET_VALID_O <= 1'b1;
    end else if (octet_done && !filt_reg) begin
      RX_OCTET_O       <= octet_val;
      RX_OCTET_VALID_O <= 1'b1;
    end else begin
      RX_OCTET_VALID_O <= 1'b0;
    end
  end

  // The end pulse of a message waits for any replay so that it follows its own data; good and filtered status update at once.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      end_pend_reg      <= 1'b0;
      RX_MSG_END_O      <= 1'b0;
      RX_MSG_GOOD_O     <= 1'b0;
      RX_MSG_FILTERED_O <= 1'b0;
    end else begin
      RX_MSG_END_O <= 1'b0;
      if (msg_valid) begin
        end_pend_reg      <= 1'b1;
        RX_MSG_GOOD_O     <= msg_good;
        RX_MSG_FILTERED_O <= filter_match;
      end else if (end_pend_reg && !rep_busy) begin
        end_pend_reg <= 1'b0;
        RX_MSG_END_O <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Octet counting
  // ****************************************************************
  assign ocm_enter = is_abort || too_long;
  // Octets are counted on raw line bits, since an aborted line has no framing to follow.
  assign line_tick = bit_en && (line_bits_reg == LAST_BIT);
  assign bad_wrap  = line_tick && ocm_reg && !ocm_enter && (bad_reg == BAD_WRAP);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      line_bits_reg <= 3'h0;
    end else if (bit_en) begin
      line_bits_reg <= line_bits_reg + 3'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ocm_reg <= 1'b0;
    end else if (ocm_enter) begin
      ocm_reg <= 1'b1;
    end else if (msg_good) begin
      ocm_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bad_reg <= 4'h0;
    end else if (ocm_enter) begin
      bad_reg <= 4'h0;
    end else if (line_tick && ocm_reg) begin
      bad_reg <= bad_reg + 4'h1;
    end
  end

  // ****************************************************************
  // Error-rate counter
  // ****************************************************************
  // A good message only ever arrives outside octet counting or as the one that ends it,
  // so the count simply holds while the mode lasts.
  assign good_wrap = msg_good && (good_reg == GOOD_WRAP);
  assign err_evt   = msg_valid && (short_err || align_err || crc_err);
  assign up_n      = {1'b0, err_evt} + {1'b0, bad_wrap};

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      good_reg <= GOOD_RESET;
    end else if (msg_good) begin
      good_reg <= good_reg + 8'h01;
    end
  end

  always_comb begin
    rate_sum = {2'b00, rate_reg} + {6'h00, up_n};
    if (good_wrap && (rate_sum != 8'h00)) begin
      rate_sum = rate_sum - 8'h01;
    end
    if (rate_sum > {2'b00, RATE_MAX}) begin
      rate_next = RATE_MAX;
    end else begin
      rate_next = rate_sum[5:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rate_reg <= RATE_RESET;
    end else begin
      rate_reg <= rate_next;
    end
  end

  // ****************************************************************
  // Interrupts and state outputs
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      FILTER_MATCH_INTERRUPT_O     <= 1'b0;
      SHORT_FRAME_ERROR_O          <= 1'b0;
      LONG_FRAME_ERROR_O           <= 1'b0;
      CRC_ERROR_INTERRUPT_O        <= 1'b0;
      ERROR_COUNT_UP_INTERRUPT_O   <= 1'b0;
      ERROR_COUNT_DOWN_INTERRUPT_O <= 1'b0;
    end else begin
      FILTER_MATCH_INTERRUPT_O     <= filter_match && !MASK_FILTER_MATCH_I;
      SHORT_FRAME_ERROR_O          <= msg_valid && short_err && !MASK_SHORT_FRAME_I;
      LONG_FRAME_ERROR_O           <= ((msg_valid && !short_err && align_err) || too_long) &&
                                      !MASK_LONG_FRAME_I;
      CRC_ERROR_INTERRUPT_O        <= msg_valid && !short_err && !align_err && crc_err &&
                                      !MASK_CRC_ERROR_I;
      ERROR_COUNT_UP_INTERRUPT_O   <= (up_n != 2'b00) && !MASK_COUNT_UP_I;
      ERROR_COUNT_DOWN_INTERRUPT_O <= good_wrap && !MASK_COUNT_DOWN_I;
    end
  end

  assign FILTERING_O               = filt_reg;
  assign OCTET_COUNTING_O          = ocm_reg;
  assign UNIT_ERROR_RATE_COUNTER_O = rate_reg;

endmodule

// ==== bench/srlm_asserts.sv ====
// Concurrent checks on the ports of the signalling link receive monitor.
`timescale 1ns/1ns
module srlm_asserts (
  // Clock and reset
  input wire logic       CLK_I,
  input wire logic       RESET_N_I,
  // Masks
  input wire logic       MASK_COUNT_UP_I,
  input wire logic       MASK_COUNT_DOWN_I,
  // Observed outputs
  input wire logic       RX_MSG_END_O,
  input wire logic       RX_MSG_GOOD_O,
  input wire logic       RX_MSG_FILTERED_O,
  input wire logic       FILTERING_O,
  input wire logic       OCTET_COUNTING_O,
  input wire logic [5:0] UNIT_ERROR_RATE_COUNTER_O,
  input wire logic       FILTER_MATCH_INTERRUPT_O,
  input wire logic       SHORT_FRAME_ERROR_O,
  input wire logic       CRC_ERROR_INTERRUPT_O,
  input wire logic       ERROR_COUNT_UP_INTERRUPT_O,
  input wire logic       ERROR_COUNT_DOWN_INTERRUPT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire logic [5:0] r = UNIT_ERROR_RATE_COUNTER_O;
  wire logic up = ERROR_COUNT_UP_INTERRUPT_O;
  wire logic dn = ERROR_COUNT_DOWN_INTERRUPT_O;
  rate_up_a: assert property (up && !dn |-> r == (($past(r) == 6'h3f) ? 6'h3f : $past(r) + 6'h01))
    else $error("rate counter did not step up");
  rate_down_a: assert property (dn && !up |-> r == (($past(r) == 6'h00) ? 6'h00 : $past(r) - 6'h01))
    else $error("rate counter did not step down");
  rate_rise_a: assert property (r > $past(r) |-> up || MASK_COUNT_UP_I)
    else $error("rate rose without count-up pulse");
  rate_fall_a: assert property (r < $past(r) |-> dn || MASK_COUNT_DOWN_I)
    else $error("rate fell without count-down pulse");
  rate_step_a: assert property ({1'b0, r} <= {1'b0, $past(r)} + 7'h01 && {1'b0, r} + 7'h01 >= {1'b0, $past(r)})
    else $error("rate counter jumped");
  crc_up_a: assert property (CRC_ERROR_INTERRUPT_O && !MASK_COUNT_UP_I |-> up)
    else $error("check error did not count up");
  short_up_a: assert property (SHORT_FRAME_ERROR_O && !MASK_COUNT_UP_I |-> up)
    else $error("short frame did not count up");
  match_end_a: assert property (FILTER_MATCH_INTERRUPT_O |-> FILTERING_O ##1 (RX_MSG_END_O && RX_MSG_FILTERED_O))
    else $error("match did not keep filtering");
  octet_exit_a: assert property ($fell(OCTET_COUNTING_O) |-> RX_MSG_GOOD_O ##[1:20] RX_MSG_END_O)
    else $error("octet counting left without good message");
  match_c: cover property (FILTER_MATCH_INTERRUPT_O);
  count_c: cover property ($rose(OCTET_COUNTING_O));
  up_c: cover property (up);
endmodule
bind srlm_top srlm_asserts u_asserts (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .MASK_COUNT_UP_I(MASK_COUNT_UP_I),
  .MASK_COUNT_DOWN_I(MASK_COUNT_DOWN_I), .RX_MSG_END_O(RX_MSG_END_O), .RX_MSG_GOOD_O(RX_MSG_GOOD_O),
  .RX_MSG_FILTERED_O(RX_MSG_FILTERED_O), .FILTERING_O(FILTERING_O), .OCTET_COUNTING_O(OCTET_COUNTING_O),
  .UNIT_ERROR_RATE_COUNTER_O(UNIT_ERROR_RATE_COUNTER_O), .FILTER_MATCH_INTERRUPT_O(FILTER_MATCH_INTERRUPT_O),
  .SHORT_FRAME_ERROR_O(SHORT_FRAME_ERROR_O), .CRC_ERROR_INTERRUPT_O(CRC_ERROR_INTERRUPT_O),
  .ERROR_COUNT_UP_INTERRUPT_O(ERROR_COUNT_UP_INTERRUPT_O), .ERROR_COUNT_DOWN_INTERRUPT_O(ERROR_COUNT_DOWN_INTERRUPT_O));

// ==== bench/srlm_link_model.sv ====
// Serial line partner sending flag-delimited, bit-stuffed messages with check sequence.
`timescale 1ns/1ns
module srlm_link_model (
  // Serial link pins
  output logic link_clk_o,
  output logic link_data_o
);
  logic [15:0] crc;
  int          ones;
  initial begin
    link_clk_o  = 1'b0;
    link_data_o = 1'b1;
  end
  // Data settles 40 ns before the rise and holds 120 ns after it.
  task automatic put_bit(input logic b);
    link_data_o = b;
    #40 link_clk_o = 1'b1;
    #80 link_clk_o = 1'b0;
    #40;
  endtask
  task automatic put_octet(input logic [7:0] o, input bit raw, input bit upd);
    for (int i = 0; i < 8; i++) begin
      if (upd) begin
        crc = (crc[0] ^ o[i]) ? ((crc >> 1) ^ 16'h8408) : (crc >> 1);
      end
      put_bit(o[i]);
      ones = o[i] ? ones + 1 : 0;
      if (!raw && ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
  endtask
  // The clock stands still between messages, so the data line is left flipped.
  task automatic send_frame(input logic [127:0] m, input int n, input bit bad);
    logic [15:0] f;
    crc  = 16'hffff;
    ones = 0;
    put_octet(8'h7e, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      put_octet(m[8*i +: 8], 1'b0, 1'b1);
    end
    f = ~crc ^ {15'h0000, bad};
    put_octet(f[7:0], 1'b0, 1'b0);
    put_octet(f[15:8], 1'b0, 1'b0);
    put_octet(8'h7e, 1'b1, 1'b0);
    link_data_o = ~link_data_o;
  endtask
  task automatic send_abort(input int n);
    put_octet(8'h7e, 1'b1, 1'b0);
    repeat (n) put_bit(1'b1);
    put_octet(8'h7e, 1'b1, 1'b0);
    link_data_o = ~link_data_o;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench of the signalling link receive monitor.
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b1;
  logic [5:0] masks = 6'h00;
  logic [7:0] max_len = 8'h0a;
  logic [7:0] octet;
  logic [7:0] first_oct;
  logic end_p, good, filt, filtering, counting;
  logic [5:0] rate;
  logic [6:0] ev;
  wire logic lclk, ldata;
  int cnt [7];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [127:0] REF = 128'h0403_0201;
  always #5 clk_i = ~clk_i;
  srlm_link_model link (.link_clk_o(lclk), .link_data_o(ldata));
  srlm_top dut (.CLK_I(clk_i), .RESET_N_I(rst_n), .RX_LINK_CLK_I(lclk), .RX_LINK_DATA_I(ldata),
    .SIGNALLING_CRC16_CHANNEL_MODE_I(mode), .MAX_FRAME_LEN_I(max_len), .MASK_FILTER_MATCH_I(masks[0]),
    .MASK_SHORT_FRAME_I(masks[1]), .MASK_LONG_FRAME_I(masks[2]), .MASK_CRC_ERROR_I(masks[3]),
    .MASK_COUNT_UP_I(masks[4]), .MASK_COUNT_DOWN_I(masks[5]), .RX_OCTET_O(octet), .RX_OCTET_VALID_O(ev[0]),
    .RX_MSG_END_O(end_p), .RX_MSG_GOOD_O(good), .RX_MSG_FILTERED_O(filt), .FILTERING_O(filtering),
    .OCTET_COUNTING_O(counting), .UNIT_ERROR_RATE_COUNTER_O(rate), .FILTER_MATCH_INTERRUPT_O(ev[1]),
    .SHORT_FRAME_ERROR_O(ev[2]), .LONG_FRAME_ERROR_O(ev[3]), .CRC_ERROR_INTERRUPT_O(ev[4]),
    .ERROR_COUNT_UP_INTERRUPT_O(ev[5]), .ERROR_COUNT_DOWN_INTERRUPT_O(ev[6]));
  // Pulses are tallied every cycle; scenarios compare the tallies of one message.
  always @(posedge clk_i) begin
    cycles++;
    if (ev[0] === 1'b1 && cnt[0] == 0) first_oct = octet;
    for (int i = 0; i < 7; i++) begin
      if (ev[i] === 1'b1) cnt[i]++;
    end
    if (cycles == 60000) begin
      errors++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic frame(input logic [127:0] m, input int n, input bit bad);
    cnt = '{default: 0};
    link.send_frame(m, n, bad);
    repeat (30) @(negedge clk_i);
  endtask
  task automatic t_filter();
    frame(REF, 4, 1'b0);
    check("octets", 8'h06, 8'(cnt[0]));
    check("filtering", 8'h01, {7'h00, filtering});
    frame(REF, 4, 1'b0);
    check("octets", 8'h00, 8'(cnt[0]));
    check("match", 8'h01, 8'(cnt[1]));
    check("filtered", 8'h01, {7'h00, filt});
    frame(128'h0407_0201, 4, 1'b0);
    check("match", 8'h00, 8'(cnt[1]));
    check("octets", 8'h06, 8'(cnt[0]));
    check("first", 8'h01, first_oct);
    check("filtering", 8'h01, {7'h00, filtering});
    frame(128'h0605_0403_0201, 6, 1'b0);
    check("filtering", 8'h00, {7'h00, filtering});
    check("octets", 8'h08, 8'(cnt[0]));
  endtask
  task automatic t_errors();
    frame(REF, 4, 1'b1);
    check("crc", 8'h01, 8'(cnt[4]));
    check("good", 8'h00, {7'h00, good});
    check("up", 8'h01, 8'(cnt[5]));
    check("rate", 8'h01, {2'b00, rate});
    frame(128'h0201, 2, 1'b0);
    check("short", 8'h01, 8'(cnt[2]));
    check("rate", 8'h02, {2'b00, rate});
    masks = 6'h08;
    frame(REF, 4, 1'b1);
    check("crc", 8'h00, 8'(cnt[4]));
    check("rate", 8'h03, {2'b00, rate});
    masks = 6'h00;
  endtask
  task automatic t_octets();
    cnt = '{default: 0};
    link.send_abort(143);
    repeat (30) @(negedge clk_i);
    check("counting", 8'h01, {7'h00, counting});
    check("up", 8'h01, 8'(cnt[5]));
    frame(REF, 4, 1'b0);
    check("counting", 8'h00, {7'h00, counting});
    check("rate", 8'h04, {2'b00, rate});
    check("good", 8'h01, {7'h00, good});
    check("down", 8'h00, 8'(cnt[6]));
    frame(128'h0c0b_0a09_0807_0605_0403_0201, 12, 1'b0);
    check("long", 8'h01, 8'(cnt[3]));
    check("counting", 8'h01, {7'h00, counting});
    frame(REF, 4, 1'b0);
    check("counting", 8'h00, {7'h00, counting});
    check("rate", 8'h04, {2'b00, rate});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_i);
    t_filter();
    t_errors();
    t_octets();
    final_report();
  end
endmodule
